// ---- rtl/dcv_device.sv ----
// What this block does
// R1: select low uses internal reference on pin
// R2: select high releases pin for outside
// R3: standby needs both mode inputs low
// R4: standby keeps reference, stops current array
// R5: enable high leaves standby, settles 50us
// R6: power-down high shuts down, enable ignored
// R7: shutdown exit settles fifty microseconds
// R8: wake resumes last pre-standby output
// R9: every rising edge captures ten bits
// R10: output follows latch one clock later
`timescale 1ns/1ns
`include "dcv_defines.svh"

module dcv_device #(
	parameter int W          = `DCV_DATA_W,
	parameter int SETTLE_CYC = `DCV_SETTLE_CYC
)(
	input  wire logic         ref_clk_i,      // converter clock
	input  wire logic         rst_n_i,        // async reset
	dcv_link_if.device        link,           // pins from host
	output logic [W-1:0]      dac_code_o,     // converter register
	output logic              array_on_o,     // current array on
	output logic              amp_on_o,       // control amp on
	output logic              int_ref_on_o,   // internal reference on
	output logic              settled_o,      // output settled
	output logic [1:0]        power_state_o   // dcv_power_type
);
	////////////////////////////////////////////////////////////////////
	localparam logic [2:0] MODE_RESET = `DCV_MODE_RESET;
	logic [2:0]      mode_pin;
	logic [2:0]      mode_sync [3];
	logic [2:0]      mode_q;
	genvar           g;
	logic            pd_q;
	logic            en_q;
	logic            rs_q;
	logic [W-1:0]    input_latch;
	logic [`DCV_CNT_W-1:0] settle_cnt;
	dcv_pkg::dcv_power_type state;
	dcv_pkg::dcv_power_type next_state;

	// three-stage sync per mode pin, change accepted when last two agree
	// bit 2 power-down select, bit 1 converter enable, bit 0 ref select
	assign mode_pin = {link.power_down_select,
	                   link.converter_enable,
	                   link.reference_select_n};

	for (g = 0; g < 3; g++)
	begin : g_sync
		always_ff @(posedge ref_clk_i or negedge rst_n_i)
			if (!rst_n_i)
			begin
				mode_sync[g] <= {3{MODE_RESET[g]}};
				mode_q[g]    <= MODE_RESET[g];
			end
			else
			begin
				mode_sync[g] <= {mode_sync[g][1:0], mode_pin[g]};
				if (mode_sync[g][2] == mode_sync[g][1])
					mode_q[g] <= mode_sync[g][2];
			end
	end

	assign pd_q = mode_q[2];
	assign en_q = mode_q[1];
	assign rs_q = mode_q[0];

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		case (state)
			dcv_pkg::DCV_ACTIVE:
				if (pd_q)
					next_state = dcv_pkg::DCV_SHUTDOWN; // [R6]
				else if (!en_q)
					next_state = dcv_pkg::DCV_STANDBY;  // [R3]
			dcv_pkg::DCV_STANDBY, dcv_pkg::DCV_SHUTDOWN:
				if (pd_q)
					next_state = dcv_pkg::DCV_SHUTDOWN; // [R6]
				else if (en_q)
					next_state = dcv_pkg::DCV_WAKING;   // [R5] [R7]
				else
					next_state = dcv_pkg::DCV_STANDBY;
			dcv_pkg::DCV_WAKING:
				if (pd_q)
					next_state = dcv_pkg::DCV_SHUTDOWN;
				else if (!en_q)
					next_state = dcv_pkg::DCV_STANDBY;
				else if (settle_cnt == `DCV_CNT_W'(SETTLE_CYC - 1))
					next_state = dcv_pkg::DCV_ACTIVE;   // [R5] [R7]
			default:
				next_state = dcv_pkg::DCV_SHUTDOWN;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			state <= dcv_pkg::DCV_SHUTDOWN;
		else
			state <= next_state;

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			settle_cnt <= '0;
		else if (state == dcv_pkg::DCV_WAKING)
			settle_cnt <= settle_cnt + 1'b1;
		else
			settle_cnt <= '0;

	////////////////////////////////////////////////////////////////////
	// data path: every edge loads the input latch
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			input_latch <= `DCV_CODE_ZERO;
		else
			input_latch <= link.sample_word;                  // [R9]

	// converter register holds while the array is off, so wake resumes it
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			dac_code_o <= `DCV_CODE_ZERO;
		else if (next_state == dcv_pkg::DCV_ACTIVE &&
		         state == dcv_pkg::DCV_ACTIVE)
			dac_code_o <= input_latch;                        // [R10] [R8]

	////////////////////////////////////////////////////////////////////
	// analog enables follow the next state, so they flip with it
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			array_on_o   <= 1'b0;
			amp_on_o     <= 1'b0;
			int_ref_on_o <= 1'b0;
		end
		else
		begin
			array_on_o   <= (next_state == dcv_pkg::DCV_ACTIVE) ||
			                (next_state == dcv_pkg::DCV_WAKING);   // [R4]
			amp_on_o     <= (next_state != dcv_pkg::DCV_SHUTDOWN); // [R4] [R6]
			int_ref_on_o <= !rs_q &&
			                (next_state != dcv_pkg::DCV_SHUTDOWN); // [R1] [R2]
		end

	// status outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			settled_o     <= 1'b0;
			power_state_o <= 2'h2;
		end
		else
		begin
			settled_o     <= (next_state == dcv_pkg::DCV_ACTIVE);  // [R5] [R7]
			power_state_o <= 2'(next_state);
		end

	// internal reference drives the pin only when selected
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			link.reference_pin_o    <= 1'b0;
			link.reference_pin_oe_n <= 1'b1;
		end
		else
		begin
			link.reference_pin_o    <= 1'b1;                      // [R1]
			link.reference_pin_oe_n <= rs_q ||
			                (next_state == dcv_pkg::DCV_SHUTDOWN); // [R2]
		end
endmodule

// ---- rtl/dcv_defines.svh ----
`ifndef DCV_DEFINES_SVH
`define DCV_DEFINES_SVH

`define DCV_DATA_W        10
`define DCV_FIFO_DEPTH    4
`define DCV_CLK_PERIOD_NS 4
`define DCV_SETTLE_US     50
`define DCV_SETTLE_CYC    ((`DCV_SETTLE_US * 1000) / `DCV_CLK_PERIOD_NS)
`define DCV_CNT_W         16
`define DCV_CODE_ZERO     10'h000
`define DCV_MODE_RESET    3'h4
`define DCV_REF_HANDOVER_CYC 8

`endif

// ---- rtl/dcv_pkg.sv ----
package dcv_pkg;
	typedef enum logic [1:0]
	{
		DCV_ACTIVE,
		DCV_STANDBY,
		DCV_SHUTDOWN,
		DCV_WAKING
	} dcv_power_type;
endpackage

// ---- rtl/dcv_link_if.sv ----
`timescale 1ns/1ns
`include "dcv_defines.svh"

interface dcv_link_if;
	logic [`DCV_DATA_W-1:0] sample_word;
	logic                   power_down_select;
	logic                   converter_enable;
	logic                   reference_select_n;
	logic                   reference_pin_i;
	logic                   reference_pin_o;
	logic                   reference_pin_oe_n;
	logic                   ext_ref_o;
	logic                   ext_ref_oe_n;

	modport device
	(
		input  sample_word,
		input  power_down_select,
		input  converter_enable,
		input  reference_select_n,
		input  reference_pin_i,
		output reference_pin_o,
		output reference_pin_oe_n
	);
	modport host
	(
		output sample_word,
		output power_down_select,
		output converter_enable,
		output reference_select_n,
		output ext_ref_o,
		output ext_ref_oe_n,
		input  reference_pin_i
	);
endinterface

// ---- rtl/dcv_fifo.sv ----
`timescale 1ns/1ns

module dcv_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
)(
	input  wire logic             ref_clk_i,  // clock
	input  wire logic             rst_n_i,    // async reset
	input  wire logic [WIDTH-1:0] in_data_i,  // write data
	input  wire logic             in_valid_i, // write valid
	output logic                  in_ready_o, // not full
	output logic      [WIDTH-1:0] out_data_o, // head word
	output logic                  out_valid_o,// not empty
	input  wire logic             out_ready_i // read accept
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge ref_clk_i)
		if (push)
			mem[wr_ptr] <= in_data_i;

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule

// ---- rtl/dcv_host.sv ----
`timescale 1ns/1ns
`include "dcv_defines.svh"

module dcv_host #(
	parameter int W     = `DCV_DATA_W,
	parameter int DEPTH = `DCV_FIFO_DEPTH
)(
	input  wire logic         ref_clk_i,      // clock
	input  wire logic         rst_n_i,        // async reset
	input  wire logic [W-1:0] sample_i,       // user sample
	input  wire logic         sample_valid_i, // sample valid
	output logic              sample_ready_o, // fifo not full
	input  wire logic         stream_go_i,    // drain one word per clock
	input  wire logic         power_down_i,   // request shutdown
	input  wire logic         enable_i,       // request active
	input  wire logic         ext_ref_i,      // use external reference
	dcv_link_if.host          link            // pins to device
);
	logic [W-1:0] head;
	logic         head_valid;
	logic         fifo_ready;
	logic [3:0]   handover_cnt;

	dcv_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (sample_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (fifo_ready),
		.out_data_o  (head),
		.out_valid_o (head_valid),
		.out_ready_i (stream_go_i)
	);

	////////////////////////////////////////////////////////////////////
	// hold off the outside reference until the device has let go of the pin
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			handover_cnt <= '0;
		else if (!ext_ref_i)
			handover_cnt <= '0;
		else if (handover_cnt != 4'(`DCV_REF_HANDOVER_CYC))
			handover_cnt <= handover_cnt + 1'b1;

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			sample_ready_o          <= 1'b0;
			link.sample_word        <= `DCV_CODE_ZERO;
			link.power_down_select  <= 1'b1;
			link.converter_enable   <= 1'b0;
			link.reference_select_n <= 1'b0;
			link.ext_ref_o          <= 1'b0;
			link.ext_ref_oe_n       <= 1'b1;
		end
		else
		begin
			sample_ready_o <= fifo_ready;
			if (stream_go_i && head_valid)
				link.sample_word <= head;
			// standby is both low; shutdown overrides enable
			link.power_down_select  <= power_down_i;  // [R3] [R6]
			link.converter_enable   <= enable_i;      // [R5] [R7]
			link.reference_select_n <= ext_ref_i;     // [R1] [R2]
			// drive the reference pin only when internal is off
			link.ext_ref_o          <= 1'b1;
			link.ext_ref_oe_n       <= !(ext_ref_i &&
			        handover_cnt == 4'(`DCV_REF_HANDOVER_CYC));  // [R2]
		end
endmodule

// ---- tb/dcv_link_asserts.sv ----
`timescale 1ns/1ns
`include "dcv_defines.svh"

module dcv_link_asserts
(
	input wire logic                   ref_clk_i,          // clock
	input wire logic                   rst_n_i,            // reset
	input wire logic [`DCV_DATA_W-1:0] sample_word,        // data pins
	input wire logic                   power_down_select,  // mode pin
	input wire logic                   converter_enable,   // mode pin
	input wire logic                   reference_select_n, // ref select
	input wire logic                   reference_pin_o,    // device ref
	input wire logic                   reference_pin_oe_n, // device oe
	input wire logic                   ext_ref_oe_n,       // host oe
	input wire logic [`DCV_DATA_W-1:0] dac_code_o,         // code
	input wire logic                   array_on_o,         // array
	input wire logic                   amp_on_o,           // amp
	input wire logic                   int_ref_on_o,       // int ref
	input wire logic                   settled_o,          // settled
	input wire logic [1:0]             power_state_o       // state
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	//////////////////////////////////////////////////////////////////////
	chk_ref_internal: assert property (
		(!reference_select_n && power_state_o != 2'h2)[*6] |->
		!reference_pin_oe_n && reference_pin_o && int_ref_on_o)
		else $error("internal reference not on pin");
	chk_ref_no_clash: assert property (
		!(!reference_pin_oe_n && !ext_ref_oe_n))
		else $error("reference pin driven by both ends");
	chk_ref_external: assert property (
		reference_select_n[*6] |-> reference_pin_oe_n && !int_ref_on_o)
		else $error("reference pin not released");
	chk_standby_state: assert property (
		(!power_down_select && !converter_enable)[*6] |->
		power_state_o == 2'h1 && amp_on_o && !array_on_o &&
		(reference_select_n || int_ref_on_o))
		else $error("standby state wrong");
	chk_shutdown_all_off: assert property (
		power_down_select[*6] |-> power_state_o == 2'h2 &&
		!array_on_o && !amp_on_o && !int_ref_on_o)
		else $error("shutdown state wrong");
	chk_wake_entry: assert property (
		(!power_down_select && converter_enable)[*6] |->
		(power_state_o == 2'h0 || power_state_o == 2'h3) && array_on_o)
		else $error("wake not entered");
	chk_wake_settle: assert property (
		$rose(power_state_o == 2'h3) |-> (!settled_o)[*6] ##[1:8]
		(power_state_o == 2'h0 && settled_o))
		else $error("settle timing wrong");
	chk_code_latency: assert property (
		(power_state_o == 2'h0)[*3] |-> dac_code_o == $past(sample_word, 2))
		else $error("code latency wrong");
	chk_code_hold: assert property (
		power_state_o != 2'h0 && $past(power_state_o) != 2'h0 |->
		$stable(dac_code_o))
		else $error("code changed while idle");
	cov_standby: cover property (power_state_o == 2'h1);
	cov_shutdown: cover property ($rose(power_state_o == 2'h2));
	cov_wake: cover property ($rose(settled_o));
	cov_ext_ref: cover property (!ext_ref_oe_n);
endmodule

// ---- tb/dac_input_and_power_mode_control_tb.sv ----
`timescale 1ns/1ns

module dac_input_and_power_mode_control_tb;
	logic       ref_clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [9:0] sample_i = 10'h000;
	logic       sample_valid_i = 1'b0;
	logic       stream_go_i = 1'b0;
	logic       power_down_i = 1'b1;
	logic       enable_i = 1'b0;
	logic       ext_ref_i = 1'b0;
	logic       sample_ready_o;
	logic [9:0] dac_code_o;
	logic       array_on_o;
	logic       amp_on_o;
	logic       int_ref_on_o;
	logic       settled_o;
	logic [1:0] power_state_o;
	int         n_fail = 0;
	int         n_compared = 0;
	int         cycles = 0;
	dcv_link_if lk();
	// resolved reference wire, floats low when nobody drives
	assign lk.reference_pin_i = !lk.reference_pin_oe_n ? lk.reference_pin_o
		: !lk.ext_ref_oe_n ? lk.ext_ref_o : 1'b0;
	dcv_host i_dcv_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.sample_i(sample_i), .sample_valid_i(sample_valid_i),
		.sample_ready_o(sample_ready_o), .stream_go_i(stream_go_i),
		.power_down_i(power_down_i), .enable_i(enable_i),
		.ext_ref_i(ext_ref_i), .link(lk.host));
	dcv_device #(.SETTLE_CYC(8)) i_dcv_device (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .link(lk.device), .dac_code_o(dac_code_o),
		.array_on_o(array_on_o), .amp_on_o(amp_on_o),
		.int_ref_on_o(int_ref_on_o), .settled_o(settled_o),
		.power_state_o(power_state_o));
	dcv_link_asserts i_dcv_link_asserts (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .sample_word(lk.sample_word),
		.power_down_select(lk.power_down_select),
		.converter_enable(lk.converter_enable),
		.reference_select_n(lk.reference_select_n),
		.reference_pin_o(lk.reference_pin_o),
		.reference_pin_oe_n(lk.reference_pin_oe_n),
		.ext_ref_oe_n(lk.ext_ref_oe_n),
		.dac_code_o(dac_code_o), .array_on_o(array_on_o),
		.amp_on_o(amp_on_o), .int_ref_on_o(int_ref_on_o),
		.settled_o(settled_o), .power_state_o(power_state_o));
	always #2 ref_clk_i = ~ref_clk_i;
	//////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task wait_st(input logic [1:0] s);
		int k;
		for (k = 0; k < 40 && power_state_o !== s; k++)
			step(1);
		chk(power_state_o, s);
	endtask
	//////////////////////////////////////////////////////////////////////
	task t_stream;
		int i;
		int n;
		int first;
		logic [9:0] last;
		power_down_i = 1'b0;
		enable_i = 1'b1;
		wait_st(2'h3);
		wait_st(2'h0);
		chk(settled_o, 1'b1);
		sample_valid_i = 1'b1;
		for (i = 0; i < 6; i++)
		begin
			sample_i = 10'h101 + i;
			step(1);
		end
		sample_valid_i = 1'b0;
		step(1);
		chk(sample_ready_o, 1'b0); // fifo full
		stream_go_i = 1'b1;
		last = dac_code_o;
		n = 0;
		first = -1;
		for (i = 0; i < 12; i++)
		begin
			step(1);
			if (dac_code_o !== last)
			begin
				if (n == 0)
					first = i;
				chk(dac_code_o, 10'h101 + n);
				n++;
				last = dac_code_o;
			end
		end
		stream_go_i = 1'b0;
		chk(n, 4); // fifo depth
		chk(first, 2);
	endtask
	task t_ref;
		ext_ref_i = 1'b1;
		step(10);
		chk(lk.reference_pin_oe_n, 1'b1);
		chk(int_ref_on_o, 1'b0);
		chk(lk.ext_ref_oe_n, 1'b0);
		chk(lk.reference_pin_i, 1'b1);
		ext_ref_i = 1'b0;
		step(8);
		chk(lk.reference_pin_oe_n, 1'b0);
		chk(int_ref_on_o, 1'b1);
		chk(lk.reference_pin_i, 1'b1);
	endtask
	task t_standby;
		enable_i = 1'b0;
		wait_st(2'h1);
		chk({array_on_o, amp_on_o, int_ref_on_o}, 3'h3);
		sample_i = 10'h2aa;
		sample_valid_i = 1'b1;
		step(1);
		sample_valid_i = 1'b0;
		stream_go_i = 1'b1;
		step(6);
		stream_go_i = 1'b0;
		chk(dac_code_o, 10'h104);
		enable_i = 1'b1;
		wait_st(2'h3);
		chk(dac_code_o, 10'h104);
		wait_st(2'h0);
		chk(dac_code_o, 10'h104);
		step(3);
		chk(dac_code_o, 10'h2aa);
	endtask
	task t_shutdown;
		power_down_i = 1'b1;
		wait_st(2'h2);
		chk({array_on_o, amp_on_o, int_ref_on_o}, 3'h0);
		chk(lk.reference_pin_oe_n, 1'b1);
		sample_i = 10'h155;
		sample_valid_i = 1'b1;
		step(1);
		sample_valid_i = 1'b0;
		stream_go_i = 1'b1;
		step(6);
		stream_go_i = 1'b0;
		power_down_i = 1'b0;
		wait_st(2'h3);
		chk(dac_code_o, 10'h2aa);
		wait_st(2'h0);
		chk(settled_o, 1'b1);
		chk(dac_code_o, 10'h2aa);
		step(1);
		chk(dac_code_o, 10'h155);
	endtask
	//////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	initial
	begin
		step(4);
		rst_n_i = 1'b1;
		step(1);
		t_stream();
		t_ref();
		t_standby();
		t_shutdown();
		report_and_stop();
	end
endmodule
